// *** dv/flmsc_core_asserts.sv ***
// checker: mode, flag and attention relations at the core ports
`timescale 1ns/1ns
module flmsc_core_asserts
  import flmsc_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // inputs
  input wire logic i_flash_trigger_pin,
  input wire flmsc_sense_t i_sense,
  // outputs
  input wire logic o_sda_oe,
  input wire logic o_attention_n_oe,
  input wire logic o_converter_enable,
  input wire logic o_flash_mode,
  input wire logic o_torch_mode,
  input wire logic o_precharge_enable,
  input wire logic o_aux_enable
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  logic driving;
  assign driving = o_flash_mode || o_torch_mode;
  AST_POR_QUIET: assert property ($rose(i_nrst) |-> (!o_attention_n_oe && !o_sda_oe && !o_aux_enable) [*8])
    else $error("output active during power-on");
  AST_READY_DARK: assert property (o_aux_enable |-> !o_converter_enable && !driving)
    else $error("converter or led on in ready mode");
  AST_DRIVE_CONV: assert property (driving |-> o_converter_enable && !(o_flash_mode && o_torch_mode))
    else $error("drive mode without converter");
  AST_PIN_LOW_STOP: assert property (!i_flash_trigger_pin [*6] |-> !o_flash_mode)
    else $error("flash running with trigger pin low");
  AST_END_PULSE: assert property ($fell(o_flash_mode) |-> ##[0:2] o_attention_n_oe [*8])
    else $error("no attention pulse after flash");
  AST_HOT_STOP: assert property (o_flash_mode && i_sense.led_hot |-> ##[1:8] !o_flash_mode && o_attention_n_oe)
    else $error("led overheat did not stop flash");
  AST_DIE_STOP: assert property (driving && i_sense.die_hot |-> ##[1:8] o_aux_enable && o_attention_n_oe)
    else $error("die overheat did not force ready");
  // six quiet cycles let the input synchronisers and any flash-end pulse settle first
  AST_OC_QUIET: assert property ((i_sense == 7'h03 && !o_attention_n_oe && !driving && !o_precharge_enable) [*6]
    |=> !o_attention_n_oe)
    else $error("overcurrent pulled attention");
  cover property ($rose(o_flash_mode));
  cover property ($fell(o_torch_mode) && o_aux_enable);
  cover property ($fell(o_precharge_enable) && !driving);
endmodule

// *** dv/flmsc_core_bench.sv ***
// bench: flash led control core against the host model
`timescale 1ns/1ns
module flmsc_core_bench import flmsc_pkg::*;;
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] data;
    logic [3:0] outs;
    logic [7:0] dim;
  } flmsc_row_t;
  localparam int STEP = 100;
  localparam logic [6:0] ADDR = 7'h30;
  logic i_clock, i_nrst = 1'b0, link_clock, scl, host_low, sda, flash_trigger_pin = 1'b0, ok;
  logic sda_out, sda_oe, attn_out, attn_oe, bias, conv, flash, torch, pre, aux;
  logic [7:0] dim_set, aux_set, q;
  flmsc_sense_t sense = 7'h01;
  int fail_count = 0, check_count = 0, on_cycles = 0, base;
  // outs is {aux, bias, torch, converter}
  flmsc_row_t rows [7] = '{
    '{8'h00, 8'h00, 4'h0, 8'h00}, '{8'h00, 8'h80, 4'h8, 8'h00}, '{8'h01, 8'h5A, 4'h8, 8'h5A},
    '{8'h00, 8'h90, 4'hC, 8'h5A}, '{8'h00, 8'hA0, 4'h3, 8'h5A}, '{8'h03, 8'hFF, 4'h3, 8'h5A},
    '{8'h00, 8'h80, 4'h8, 8'h5A}};
  flmsc_core #(.STEP_CYCLES(STEP)) i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_scl_clock(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_flash_trigger_pin(flash_trigger_pin), .i_addr_select(1'b0),
    .o_attention_n_out(attn_out), .o_attention_n_oe(attn_oe), .i_sense(sense), .o_thermistor_bias_switch(bias),
    .o_converter_enable(conv), .o_flash_mode(flash), .o_torch_mode(torch), .o_precharge_enable(pre),
    .o_aux_enable(aux), .o_dim_setting(dim_set), .o_aux_setting(aux_set));
  flmsc_host_model i_host (.i_link_clock(link_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  // pulled-up data wire
  assign sda = !(host_low || sda_oe);
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    link_clock = 1'b0;
    #13;
    forever #32 link_clock = ~link_clock;
  end
  always @(posedge i_clock) on_cycles <= on_cycles + int'(flash);
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    i_host.write_reg(ADDR, sub, d, ok);
    clk(20);
  endtask
  task automatic rd(input logic [7:0] exp);
    i_host.read_stat(ADDR, q);
    check("status", exp, q);
    clk(2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #4000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    clk(20);
    i_nrst <= 1'b1;
    clk(20);
    foreach (rows[n]) begin
      wr(rows[n].sub, rows[n].data);
      check("ack", 8'h01, 8'(ok));
      check("modes", 8'(rows[n].outs), 8'({aux, bias, torch, conv}));
      check("dim", rows[n].dim, dim_set);
    end
    i_host.write_reg(7'h31, 8'h00, 8'h00, ok);
    check("foreign ack", 8'h00, 8'(ok));
    check("aux kept", 8'h01, 8'(aux));
    $display("table done");
    wr(8'h00, 8'hC3);
    flash_trigger_pin <= 1'b1;
    clk(75);
    check("flash on", 8'h01, 8'(flash));
    clk(75);
    flash_trigger_pin <= 1'b0;
    clk(10);
    check("pin low ends", 8'h00, 8'(flash));
    flash_trigger_pin <= 1'b1;
    clk(220);
    check("accumulated", 8'h00, 8'(flash));
    check("ready again", 8'h01, 8'(aux));
    $display("hard trigger done");
    base = on_cycles;
    wr(8'h00, 8'hC2);
    clk(300);
    check("flash length", 8'h01, 8'((on_cycles - base) inside {[2*STEP-5:2*STEP+5]}));
    wr(8'h00, 8'hCF);
    rd(8'h40);
    wr(8'h00, 8'hCF);
    clk(900);
    check("extended", 8'h01, 8'(flash));
    clk(700);
    rd(8'h00);
    $display("soft trigger done");
    wr(8'h00, 8'hCF);
    clk(30);
    sense.led_hot <= 1'b1;
    clk(10);
    sense.led_hot <= 1'b0;
    flash_trigger_pin <= 1'b0;
    check("hot stop", 8'h02, 8'({attn_oe, flash}));
    rd(8'h08);
    wr(8'h00, 8'h90);
    sense.led_warm <= 1'b1;
    clk(10);
    sense.led_warm <= 1'b0;
    clk(5);
    check("warm", 8'h03, 8'({attn_oe, aux}));
    rd(8'h10);
    clk(5);
    check("attention freed", 8'h00, 8'(attn_oe));
    rd(8'h00);
    sense.inductor_peak <= 1'b1;
    clk(10);
    check("oc attention", 8'h00, 8'(attn_oe));
    rd(8'h02);
    sense.inductor_peak <= 1'b0;
    rd(8'h00);
    $display("flags done");
    wr(8'h00, 8'hA0);
    sense.die_hot <= 1'b1;
    clk(10);
    sense.die_hot <= 1'b0;
    check("die hot", 8'h03, 8'({attn_oe, aux}));
    // torch re-enters once the flag is read away, now against a shorted output
    sense.vout_ok <= 1'b0;
    rd(8'h04);
    clk(20);
    check("precharging", 8'h01, 8'(pre));
    clk(3700);
    check("start aborted", 8'h02, 8'({attn_oe, torch}));
    sense.vout_ok <= 1'b1;
    rd(8'h01);
    wr(8'h00, 8'h00);
    check("shutdown", 8'h00, 8'({aux, torch, conv, bias}));
    $display("protection done");
    wr(8'h01, 8'h33);
    i_nrst <= 1'b0;
    clk(20);
    i_nrst <= 1'b1;
    clk(20);
    check("reset dim", 8'h00, dim_set);
    rd(8'h00);
    $display("reset done");
    tally_and_finish();
  end
endmodule
bind flmsc_core flmsc_core_asserts u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_flash_trigger_pin(i_flash_trigger_pin), .i_sense(i_sense), .o_sda_oe(o_sda_oe),
  .o_attention_n_oe(o_attention_n_oe), .o_converter_enable(o_converter_enable), .o_flash_mode(o_flash_mode),
  .o_torch_mode(o_torch_mode), .o_precharge_enable(o_precharge_enable), .o_aux_enable(o_aux_enable));

// *** dv/flmsc_host_model.sv ***
// host model: bus master paced by the link clock
`timescale 1ns/1ns
module flmsc_host_model (
  // link clock
  input wire logic i_link_clock,
  // bus wires, data is open drain
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_link_clock);
  endtask
  // scl moves only inside frames; 8 link cycles high so the core sees start and stop
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    r = i_sda;
    tick(4);
    o_scl <= 1'b0;
    tick(4);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic start();
    o_sda_low <= 1'b1;
    tick(8);
    o_scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    tick(4);
    o_scl <= 1'b1;
    tick(8);
    o_sda_low <= 1'b0;
    tick(8);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    byte_io({a, 1'b0}, q, k1);
    byte_io(sub, q, k2);
    byte_io(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // point at the status register, then read one byte and end with a nack
  task automatic read_stat(input logic [6:0] a, output logic [7:0] q);
    logic k;
    start();
    byte_io({a, 1'b0}, q, k);
    byte_io(8'h03, q, k);
    stop();
    start();
    byte_io({a, 1'b1}, q, k);
    byte_io(8'hFF, q, k);
    stop();
  endtask
endmodule

// *** src/flmsc_core.sv ***
// flash led control: mode sequencer, status flags, flash timer and register file
// Functional notes
// (RQ1) led overheat sets flag, attention, ready
// (RQ2) latched flags clear only on status read
// (RQ3) die overheat sets flag, attention, ready
// (RQ4) overcurrent mirrors input, never pulls attention
// (RQ5) running and overcurrent bits follow sources live
// (RQ6) output not ok high during output precharge
// (RQ7) precharge timeout latches flag, aborts start
// (RQ8) power-on period ignores inputs, samples address
// (RQ9) shutdown after power-on or power bit clear
// (RQ10) power plus thermistor bits switch bias on
// (RQ11) ready: converter off, aux only here
// (RQ12) ready on trigger drop, timeout, torch clear
// (RQ13) forcing flags return drive modes to ready
// (RQ14) host re-arms trigger enable every flash
// (RQ15) hard trigger flash lasts while pin held
// (RQ16) host programs timer before flashing
// (RQ17) timer accumulates until command register rewrite
// (RQ18) expiry clears trigger enable, attention, ready
// (RQ19) attention low pulse when flash ends
// (RQ20) soft trigger: pin high, command write
// (RQ21) host rewrites timer to extend flash
// (RQ22) host rewrites command for each flash
// (RQ23) flash on needs enable, pin and power
// (RQ24) timer steps of 100 ms, value kept
// (RQ25) led warm sets flag and attention only
// (RQ26) running bit high exactly in flash mode
// (RQ27) attention released once latched flags cleared
// (RQ28) read returns snapshot, clear after byte sent
`timescale 1ns/1ns
`include "flmsc_defines.svh"
module flmsc_core
  import flmsc_pkg::*;
#(
  parameter int STEP_CYCLES = `FLMSC_FLASH_STEP_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // serial bus
  input wire logic i_scl_clock,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // pins
  input wire logic i_flash_trigger_pin,
  input wire logic i_addr_select,
  output logic o_attention_n_out,
  output logic o_attention_n_oe,
  // analog side
  input wire flmsc_sense_t i_sense,
  output logic o_thermistor_bias_switch,
  output logic o_converter_enable,
  output logic o_flash_mode,
  output logic o_torch_mode,
  output logic o_precharge_enable,
  output logic o_aux_enable,
  output logic [7:0] o_dim_setting,
  output logic [7:0] o_aux_setting
);

  flmsc_state_t st;
  flmsc_state_t next_st;
  logic link_nrst;
  logic [7:0] rx_byte;
  logic rx_sub;
  logic rx_toggle;
  logic rd_toggle;
  logic tx_toggle;
  logic [6:0] addr_base;

  assign addr_base = `FLMSC_SLAVE_ADDR_BASE;
  function automatic logic [7:0] status_word(input flmsc_state_t s);
    logic [7:0] w;
    w = s.latched & `FLMSC_LATCH_MASK;
    w[`FLMSC_BIT_FLASH_RUNNING] = (s.mode == FLMSC_FLASH); // RQ26
    w[`FLMSC_BIT_OVERCURRENT] = s.sense_s2.inductor_peak; // RQ4 RQ5
    w[`FLMSC_BIT_OUTPUT_NOT_OK] = w[`FLMSC_BIT_OUTPUT_NOT_OK] | (s.mode == FLMSC_CHARGE); // RQ6
    return w;
  endfunction

  function automatic logic is_drive(input flmsc_mode_t m);
    return (m == FLMSC_FLASH) || (m == FLMSC_TORCH);
  endfunction

  // link domain is held in reset while the bus is idle and at every start
  assign link_nrst = i_nrst & ~st.link_hold;

  flmsc_i2c_link u_link (
    .i_scl_clock(i_scl_clock),
    .i_link_nrst(link_nrst),
    .i_sda(i_sda),
    .i_slave_addr({addr_base[6:1], st.addr_lsb}),
    .i_read_byte(st.rd_snap),
    .o_sda_oe(o_sda_oe),
    .o_rx_byte(rx_byte),
    .o_rx_sub(rx_sub),
    .o_rx_toggle(rx_toggle),
    .o_rd_toggle(rd_toggle),
    .o_tx_toggle(tx_toggle)
  );

  always_comb begin
    logic start_seen;
    logic stop_seen;
    logic rx_ev;
    logic rd_ev;
    logic tx_ev;
    logic cmd_written;
    logic flash_on;
    logic forcing;
    logic expire;
    logic ntc_watch;
    logic powered;
    logic [7:0] sets;
    start_seen = 1'h0;
    stop_seen = 1'h0;
    rx_ev = 1'h0;
    rd_ev = 1'h0;
    tx_ev = 1'h0;
    cmd_written = 1'h0;
    flash_on = 1'h0;
    forcing = 1'h0;
    expire = 1'h0;
    ntc_watch = 1'h0;
    powered = 1'h0;
    sets = 8'h00;
    next_st = st;

    // two-stage synchronisers for pins and link-domain toggles
    next_st.sda_s1 = i_sda;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_s3 = st.sda_s2;
    next_st.scl_s1 = i_scl_clock;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_s3 = st.scl_s2;
    next_st.flash_trigger_pin_s1 = i_flash_trigger_pin;
    next_st.flash_trigger_pin_s2 = st.flash_trigger_pin_s1;
    next_st.addr_s1 = i_addr_select;
    next_st.addr_s2 = st.addr_s1;
    next_st.sense_s1 = i_sense;
    next_st.sense_s2 = st.sense_s1;
    next_st.rxt_s1 = rx_toggle;
    next_st.rxt_s2 = st.rxt_s1;
    next_st.rxt_s3 = st.rxt_s2;
    next_st.rdt_s1 = rd_toggle;
    next_st.rdt_s2 = st.rdt_s1;
    next_st.rdt_s3 = st.rdt_s2;
    next_st.txt_s1 = tx_toggle;
    next_st.txt_s2 = st.txt_s1;
    next_st.txt_s3 = st.txt_s2;

    start_seen = st.scl_s2 & st.scl_s3 & st.sda_s3 & ~st.sda_s2;
    stop_seen = st.scl_s2 & st.scl_s3 & ~st.sda_s3 & st.sda_s2;
    if (stop_seen) begin
      next_st.bus_busy = 1'h0;
    end else if (start_seen) begin
      next_st.bus_busy = 1'h1;
    end
    next_st.link_hold = ~next_st.bus_busy | start_seen | (st.mode == FLMSC_POR); // RQ8

    // holding the link drops its toggles to zero, so edges seen while held are no events
    rx_ev = (st.rxt_s2 ^ st.rxt_s3) & !st.link_hold;
    rd_ev = (st.rdt_s2 ^ st.rdt_s3) & !st.link_hold;
    tx_ev = (st.txt_s2 ^ st.txt_s3) & !st.link_hold;

    // register writes; a command write reloads the flash timer
    if (rx_ev) begin
      if (rx_sub) begin
        next_st.ptr = rx_byte[1:0];
      end else begin
        case (st.ptr)
          `FLMSC_SUB_CMD: begin
            next_st.cmd = flmsc_cmd_t'(rx_byte);
            next_st.step_cnt = rx_byte[3:0]; // RQ17
            next_st.pre_cnt = 20'h00000;
            cmd_written = 1'h1;
          end
          `FLMSC_SUB_DIM: next_st.dim = rx_byte;
          `FLMSC_SUB_AUX: next_st.aux = rx_byte;
          default: begin
          end
        endcase
        next_st.ptr = st.ptr + 2'h1;
      end
    end

    // snapshot taken once per read frame so a clear cannot race the shift-out
    if (rd_ev) begin
      case (st.ptr)
        `FLMSC_SUB_CMD: next_st.rd_snap = st.cmd;
        `FLMSC_SUB_DIM: next_st.rd_snap = st.dim;
        `FLMSC_SUB_AUX: next_st.rd_snap = st.aux;
        default: next_st.rd_snap = status_word(st); // RQ28
      endcase
    end

    powered = (st.mode != FLMSC_POR) && (st.mode != FLMSC_SHUTDOWN);
    flash_on = st.cmd.trigger_enable_bit & st.flash_trigger_pin_s2 & st.cmd.power_enable_bit; // RQ23 RQ15 RQ20
    forcing = |(st.latched & `FLMSC_FORCE_MASK);
    ntc_watch = is_drive(st.mode) | (powered & st.cmd.thermistor_enable_bit);

    // latched flag sources
    sets[`FLMSC_BIT_LED_SHORT] = is_drive(st.mode) & st.sense_s2.led_short;
    sets[`FLMSC_BIT_LED_OPEN] = is_drive(st.mode) & st.sense_s2.led_open;
    sets[`FLMSC_BIT_LED_WARM] = ntc_watch & st.sense_s2.led_warm; // RQ25
    sets[`FLMSC_BIT_LED_HOT] = ntc_watch & st.sense_s2.led_hot; // RQ1
    sets[`FLMSC_BIT_DIE_HOT] = powered & st.sense_s2.die_hot; // RQ3
    sets[`FLMSC_BIT_OUTPUT_NOT_OK] = (st.mode == FLMSC_CHARGE) && !st.sense_s2.vout_ok &&
                                     (st.charge_cnt == 12'(`FLMSC_CHARGE_CYC - 1)); // RQ7

    // timer counts only in flash mode, holding its remainder between pulses
    if (st.mode == FLMSC_FLASH && !cmd_written) begin
      expire = (st.step_cnt == 4'h0); // RQ24
      if (st.pre_cnt == 20'(STEP_CYCLES - 1)) begin
        next_st.pre_cnt = 20'h00000;
        if (st.step_cnt != 4'h0) begin
          next_st.step_cnt = st.step_cnt - 4'h1;
        end
      end else begin
        next_st.pre_cnt = st.pre_cnt + 20'h00001;
      end
    end

    case (st.mode)
      FLMSC_POR: begin
        next_st.por_cnt = st.por_cnt + 4'h1;
        if (st.por_cnt == 4'(`FLMSC_POR_CYC - 1)) begin
          next_st.addr_lsb = st.addr_s2; // RQ8
          next_st.mode = FLMSC_SHUTDOWN; // RQ9
        end
      end
      FLMSC_SHUTDOWN: begin
        if (st.cmd.power_enable_bit) begin
          next_st.mode = FLMSC_READY; // RQ12
        end
      end
      FLMSC_READY: begin
        next_st.charge_cnt = 12'h000;
        if (!st.cmd.power_enable_bit) begin
          next_st.mode = FLMSC_SHUTDOWN; // RQ9
        end else if (!forcing && flash_on) begin
          next_st.mode = FLMSC_CHARGE;
          next_st.charge_torch = 1'h0;
        end else if (!forcing && st.cmd.torch_enable_bit) begin
          next_st.mode = FLMSC_CHARGE;
          next_st.charge_torch = 1'h1;
        end
      end
      FLMSC_CHARGE: begin
        next_st.charge_cnt = st.charge_cnt + 12'h001;
        if (!st.cmd.power_enable_bit) begin
          next_st.mode = FLMSC_SHUTDOWN;
        end else if (forcing || sets[`FLMSC_BIT_OUTPUT_NOT_OK]) begin
          next_st.mode = FLMSC_READY; // RQ7
        end else if (st.charge_torch ? !st.cmd.torch_enable_bit : !flash_on) begin
          next_st.mode = FLMSC_READY;
        end else if (st.sense_s2.vout_ok) begin
          next_st.mode = st.charge_torch ? FLMSC_TORCH : FLMSC_FLASH; // RQ6
        end
      end
      FLMSC_FLASH: begin
        if (!st.cmd.power_enable_bit) begin
          next_st.mode = FLMSC_SHUTDOWN; // RQ9
        end else if (forcing) begin
          next_st.mode = FLMSC_READY; // RQ13
        end else if (expire) begin
          next_st.cmd.trigger_enable_bit = 1'h0; // RQ18
          next_st.mode = FLMSC_READY;
        end else if (!flash_on) begin
          next_st.mode = FLMSC_READY; // RQ12
        end
      end
      FLMSC_TORCH: begin
        if (!st.cmd.power_enable_bit) begin
          next_st.mode = FLMSC_SHUTDOWN;
        end else if (forcing) begin
          next_st.mode = FLMSC_READY; // RQ13
        end else if (!st.cmd.torch_enable_bit) begin
          next_st.mode = FLMSC_READY; // RQ12
        end
      end
      default: next_st.mode = FLMSC_SHUTDOWN;
    endcase

    // clear what the master has received, but a new event in the same cycle wins
    if (tx_ev && st.ptr == `FLMSC_SUB_STAT) begin
      next_st.latched = st.latched & ~(st.rd_snap & `FLMSC_LATCH_MASK); // RQ2 RQ28
    end
    next_st.latched = next_st.latched | sets;

    if (st.pulse_cnt != 7'h00) begin
      next_st.pulse_cnt = st.pulse_cnt - 7'h01;
    end
    if (st.mode == FLMSC_FLASH && next_st.mode != FLMSC_FLASH) begin
      next_st.pulse_cnt = 7'(`FLMSC_ATTN_PULSE_CYC); // RQ19
    end

    // overcurrent and running bits are not in the mask, so they never pull attention
    next_st.attn_oe = ((|(next_st.latched & `FLMSC_ATTN_MASK)) || next_st.pulse_cnt != 7'h00) &&
                      (next_st.mode != FLMSC_POR); // RQ27 RQ4

    next_st.therm_bias = st.cmd.power_enable_bit & st.cmd.thermistor_enable_bit &
                         (next_st.mode != FLMSC_POR); // RQ10
    next_st.conv_en = is_drive(next_st.mode); // RQ11
    next_st.flash_out = (next_st.mode == FLMSC_FLASH);
    next_st.torch_out = (next_st.mode == FLMSC_TORCH);
    next_st.precharge = (next_st.mode == FLMSC_CHARGE);
    next_st.aux_en = (next_st.mode == FLMSC_READY); // RQ11
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.mode <= FLMSC_POR;
      st.cmd <= flmsc_cmd_t'(`FLMSC_CMD_RST);
      st.dim <= `FLMSC_DIM_RST;
      st.aux <= `FLMSC_AUX_RST;
      st.latched <= `FLMSC_STAT_RST;
      st.link_hold <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign o_sda_out = 1'h0;
  assign o_attention_n_out = 1'h0;
  assign o_attention_n_oe = st.attn_oe;
  assign o_thermistor_bias_switch = st.therm_bias;
  assign o_converter_enable = st.conv_en;
  assign o_flash_mode = st.flash_out;
  assign o_torch_mode = st.torch_out;
  assign o_precharge_enable = st.precharge;
  assign o_aux_enable = st.aux_en;
  assign o_dim_setting = st.dim;
  assign o_aux_setting = st.aux;

endmodule

// *** src/flmsc_defines.svh ***
// flash led control: offsets, field positions, reset values and timing counts
`ifndef FLMSC_DEFINES_SVH
`define FLMSC_DEFINES_SVH

// register sub-addresses
`define FLMSC_SUB_CMD 2'h0
`define FLMSC_SUB_DIM 2'h1
`define FLMSC_SUB_AUX 2'h2
`define FLMSC_SUB_STAT 2'h3

// status word bit positions
`define FLMSC_BIT_LED_SHORT 7
`define FLMSC_BIT_FLASH_RUNNING 6
`define FLMSC_BIT_LED_OPEN 5
`define FLMSC_BIT_LED_WARM 4
`define FLMSC_BIT_LED_HOT 3
`define FLMSC_BIT_DIE_HOT 2
`define FLMSC_BIT_OVERCURRENT 1
`define FLMSC_BIT_OUTPUT_NOT_OK 0

// which status bits latch, force ready mode, pull attention low
`define FLMSC_LATCH_MASK 8'hBD
`define FLMSC_FORCE_MASK 8'h2D
`define FLMSC_ATTN_MASK 8'hBD

// reset values
`define FLMSC_CMD_RST 8'h00
`define FLMSC_DIM_RST 8'h00
`define FLMSC_AUX_RST 8'h00
`define FLMSC_STAT_RST 8'h00

// slave address: upper six bits fixed (arbitrary value), lsb from the select pin
`define FLMSC_SLAVE_ADDR_BASE 7'h30

// timing
`define FLMSC_CLK_KHZ 10000
`define FLMSC_POR_US 1
`define FLMSC_POR_CYC ((`FLMSC_POR_US * `FLMSC_CLK_KHZ) / 1000)
`define FLMSC_CHARGE_US 360
`define FLMSC_CHARGE_CYC ((`FLMSC_CHARGE_US * `FLMSC_CLK_KHZ) / 1000)
`define FLMSC_ATTN_PULSE_US 11
`define FLMSC_ATTN_PULSE_CYC ((`FLMSC_ATTN_PULSE_US * `FLMSC_CLK_KHZ) / 1000)
`define FLMSC_FLASH_STEP_MS 100
`define FLMSC_FLASH_STEP_CYC (`FLMSC_FLASH_STEP_MS * `FLMSC_CLK_KHZ)

`endif

// *** src/flmsc_i2c_link.sv ***
// flash led control: serial bus slave shifter on the bus clock
`timescale 1ns/1ns
`include "flmsc_defines.svh"
module flmsc_i2c_link
  import flmsc_pkg::*;
(
  // bus clock domain
  input wire logic i_scl_clock,
  input wire logic i_link_nrst,
  input wire logic i_sda,
  // from the core, stable while used
  input wire logic [6:0] i_slave_addr,
  input wire logic [7:0] i_read_byte,
  // to the core, toggles mark events, data held until the next byte
  output logic o_sda_oe,
  output logic [7:0] o_rx_byte,
  output logic o_rx_sub,
  output logic o_rx_toggle,
  output logic o_rd_toggle,
  output logic o_tx_toggle
);

  flmsc_link_state_t st;
  flmsc_link_state_t next_st;
  logic sda_drive;

  always_comb begin
    logic [7:0] sh;
    sh = {st.shreg[6:0], i_sda};
    next_st = st;
    next_st.shreg = sh;
    next_st.bitcnt = st.bitcnt + 4'h1;
    if (st.bitcnt == 4'h8) begin
      // acknowledge clock: our ack or the master's ack of read data
      next_st.bitcnt = 4'h0;
      next_st.out_low = 1'h0;
      if (st.phase == FLMSC_L_RSTART || (st.phase == FLMSC_L_RDATA && !i_sda)) begin
        next_st.txreg = i_read_byte;
        next_st.out_low = ~i_read_byte[7];
        next_st.phase = FLMSC_L_RDATA;
      end else if (st.phase == FLMSC_L_RDATA) begin
        next_st.phase = FLMSC_L_IGNORE;
      end
      if (st.phase == FLMSC_L_RDATA) begin
        next_st.tx_toggle = ~st.tx_toggle;
      end
    end else if (st.bitcnt == 4'h7) begin
      next_st.out_low = 1'h0;
      case (st.phase)
        FLMSC_L_ADDR: begin
          if (sh[7:1] == i_slave_addr) begin
            next_st.out_low = 1'h1;
            if (sh[0]) begin
              next_st.phase = FLMSC_L_RSTART;
              next_st.rd_toggle = ~st.rd_toggle;
            end else begin
              next_st.phase = FLMSC_L_SUB;
            end
          end else begin
            next_st.phase = FLMSC_L_IGNORE;
          end
        end
        FLMSC_L_SUB, FLMSC_L_WDATA: begin
          next_st.out_low = 1'h1;
          next_st.rx_byte = sh;
          next_st.rx_sub = (st.phase == FLMSC_L_SUB);
          next_st.rx_toggle = ~st.rx_toggle;
          next_st.phase = FLMSC_L_WDATA;
        end
        default: begin
        end
      endcase
    end else if (st.phase == FLMSC_L_RDATA) begin
      next_st.txreg = {st.txreg[6:0], 1'h0};
      next_st.out_low = ~st.txreg[6];
    end
  end

  always_ff @(posedge i_scl_clock or negedge i_link_nrst) begin
    if (!i_link_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // sda may only change while the clock is low
  always_ff @(negedge i_scl_clock or negedge i_link_nrst) begin
    if (!i_link_nrst) begin
      sda_drive <= 1'h0;
    end else begin
      sda_drive <= st.out_low;
    end
  end

  assign o_sda_oe = sda_drive;
  assign o_rx_byte = st.rx_byte;
  assign o_rx_sub = st.rx_sub;
  assign o_rx_toggle = st.rx_toggle;
  assign o_rd_toggle = st.rd_toggle;
  assign o_tx_toggle = st.tx_toggle;

endmodule

// *** src/flmsc_pkg.sv ***
// flash led control: shared types
package flmsc_pkg;

  typedef enum logic [2:0] {
    FLMSC_POR,
    FLMSC_SHUTDOWN,
    FLMSC_READY,
    FLMSC_CHARGE,
    FLMSC_FLASH,
    FLMSC_TORCH
  } flmsc_mode_t;

  typedef struct packed {
    logic power_enable_bit;
    logic trigger_enable_bit;
    logic torch_enable_bit;
    logic thermistor_enable_bit;
    logic [3:0] flash_timeout_value;
  } flmsc_cmd_t;

  // comparator and sense inputs from the analog side
  typedef struct packed {
    logic led_short;
    logic led_open;
    logic led_warm;
    logic led_hot;
    logic die_hot;
    logic inductor_peak;
    logic vout_ok;
  } flmsc_sense_t;

  typedef enum logic [2:0] {
    FLMSC_L_ADDR,
    FLMSC_L_SUB,
    FLMSC_L_WDATA,
    FLMSC_L_RSTART,
    FLMSC_L_RDATA,
    FLMSC_L_IGNORE
  } flmsc_link_phase_t;

  typedef struct packed {
    flmsc_link_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic out_low;
    logic [7:0] rx_byte;
    logic rx_sub;
    logic rx_toggle;
    logic rd_toggle;
    logic tx_toggle;
  } flmsc_link_state_t;

  typedef struct packed {
    flmsc_mode_t mode;
    logic [3:0] por_cnt;
    logic [11:0] charge_cnt;
    logic charge_torch;
    logic addr_lsb;
    logic [1:0] ptr;
    flmsc_cmd_t cmd;
    logic [7:0] dim;
    logic [7:0] aux;
    logic [7:0] latched;
    logic [7:0] rd_snap;
    logic [3:0] step_cnt;
    logic [19:0] pre_cnt;
    logic [6:0] pulse_cnt;
    logic sda_s1, sda_s2, sda_s3;
    logic scl_s1, scl_s2, scl_s3;
    logic flash_trigger_pin_s1, flash_trigger_pin_s2;
    logic addr_s1, addr_s2;
    flmsc_sense_t sense_s1;
    flmsc_sense_t sense_s2;
    logic rxt_s1, rxt_s2, rxt_s3;
    logic rdt_s1, rdt_s2, rdt_s3;
    logic txt_s1, txt_s2, txt_s3;
    logic bus_busy;
    logic link_hold;
    logic attn_oe;
    logic therm_bias;
    logic conv_en;
    logic flash_out;
    logic torch_out;
    logic precharge;
    logic aux_en;
  } flmsc_state_t;

endpackage
